// file: rtl/dep_map.svh
// Offsets, indices, field positions and reset values of the pixel register bank
`ifndef DEP_MAP_SVH
`define DEP_MAP_SVH

`define DEP_OFS_CMD    16'h9AE8
`define DEP_OFS_MASK   16'hAEE8
`define DEP_OFS_CMP    16'hB2E8
`define DEP_OFS_BGMIX  16'hB6E8
`define DEP_OFS_FGMIX  16'hBAE8
`define DEP_OFS_IDX    16'hBEE8

`define DEP_IX_HEIGHT  4'h0
`define DEP_IX_TOP     4'h1
`define DEP_IX_LEFT    4'h2
`define DEP_IX_MISC    4'hE
`define DEP_IX_RDSEL   4'hF

`define DEP_RB_HEIGHT  4'h0
`define DEP_RB_TOP     4'h1
`define DEP_RB_LEFT    4'h2
`define DEP_RB_MISC    4'h6

`define DEP_MISC_UPPER 4
`define DEP_MISC_POL   7
`define DEP_MISC_CMPEN 8
`define DEP_MISC_WIDE  9

`define DEP_RST_WORD   32'h0000_0000
`define DEP_RST_FIELD  12'h000
`define DEP_RST_HALF   16'h0000

`endif

// file: rtl/dep_pkg.sv
// Types shared by the pixel register bank modules
package dep_pkg;

    typedef enum logic [1:0]
    {
        DEP_SRC_BG   = 2'b00,
        DEP_SRC_FG   = 2'b01,
        DEP_SRC_HOST = 2'b10,
        DEP_SRC_MEM  = 2'b11
    } dep_src_t;

    typedef struct packed
    {
        dep_src_t   src;
        logic [3:0] mix;
    } dep_mix_t;

    typedef struct packed
    {
        logic        pendValid;
        logic [15:0] pendWord;
        logic        outValid;
        logic [15:0] outWord;
    } dep_pipe_st_t;

    typedef struct packed
    {
        logic        valid;
        logic [31:0] color;
        logic [31:0] we;
    } dep_mixu_st_t;

    typedef struct packed
    {
        logic [31:0] cmpValue;
        logic [31:0] planeMask;
        dep_mix_t    bgMix;
        dep_mix_t    fgMix;
        logic [11:0] height;
        logic [11:0] clipTop;
        logic [11:0] clipLeft;
        logic [11:0] misc;
        logic [3:0]  readIdx;
        logic [31:0] rdData;
        logic        rdValid;
    } dep_regs_st_t;

endpackage

// file: rtl/dep_cfg_if.sv
// Configuration carried from the register bank to the pixel mix unit
`timescale 1ns/100ps
interface dep_cfg_if;
    dep_pkg::dep_mix_t bgMix;
    dep_pkg::dep_mix_t fgMix;
    logic              compareEn;
    logic              comparePol;
    logic [31:0]       compareValue;
    logic [31:0]       planeMask;

    modport regs (output bgMix, fgMix, compareEn, comparePol, compareValue, planeMask);
    modport mixu (input bgMix, fgMix, compareEn, comparePol, compareValue, planeMask);
endinterface

// file: rtl/dep_wr_pipe.sv
// One-deep holding stage for indexed register writes
`timescale 1ns/100ps
`include "dep_map.svh"
module dep_wr_pipe
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // New indexed write
    input  wire logic        pushValid,
    input  wire logic [15:0] pushWord,
    input  wire logic        flush,
    // Write landing in the register file
    output logic             commitValid,
    output logic [15:0]      commitWord
);

    dep_pkg::dep_pipe_st_t q;
    dep_pkg::dep_pipe_st_t d;

    always_comb
    begin
        d          = q;
        d.outValid = 1'b0;
        // A held write lands only when pushed out or flushed
        if (q.pendValid && (pushValid || flush))
        begin
            d.outValid  = 1'b1;
            d.outWord   = q.pendWord;
            d.pendValid = 1'b0;
        end
        if (pushValid)
        begin
            d.pendValid = 1'b1;
            d.pendWord  = pushWord;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            q <= '{1'b0, `DEP_RST_HALF, 1'b0, `DEP_RST_HALF};
        else
            q <= d;
    end

    assign commitValid = q.outValid;
    assign commitWord  = q.outWord;

endmodule

// file: rtl/dep_mix_unit.sv
// Per-pixel color source, compare and logical mix
`timescale 1ns/100ps
`include "dep_map.svh"
module dep_mix_unit
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Configuration
    dep_cfg_if.mixu          cfg,
    // Pixel request
    input  wire logic        pixReq,
    input  wire logic        pixUseFg,
    input  wire logic        pixTransfer,
    input  wire logic [31:0] bgColor,
    input  wire logic [31:0] fgColor,
    input  wire logic [31:0] hostColor,
    input  wire logic [31:0] curColor,
    input  wire logic [31:0] writeMask,
    // Pixel result
    output logic             pixOutValid,
    output logic [31:0]      pixOut,
    output logic [31:0]      pixWe
);

    dep_pkg::dep_mixu_st_t q;
    dep_pkg::dep_mixu_st_t d;

    function automatic logic [31:0] dep_mix(input logic [3:0] op,
                                            input logic [31:0] c,
                                            input logic [31:0] n);
        unique case (op)
            4'h0: dep_mix = ~c;
            4'h1: dep_mix = 32'h0000_0000;
            4'h2: dep_mix = 32'hFFFF_FFFF;
            4'h3: dep_mix = c;
            4'h4: dep_mix = ~n;
            4'h5: dep_mix = c ^ n;
            4'h6: dep_mix = ~(c ^ n);
            4'h7: dep_mix = n;
            4'h8: dep_mix = ~c | ~n;
            4'h9: dep_mix = c | ~n;
            4'hA: dep_mix = ~c | n;
            4'hB: dep_mix = c | n;
            4'hC: dep_mix = c & n;
            4'hD: dep_mix = ~c & n;
            4'hE: dep_mix = c & ~n;
            4'hF: dep_mix = ~c & ~n;
        endcase
    endfunction

    dep_pkg::dep_mix_t sel;
    logic [31:0]       newColor;
    logic              match;
    logic              suppress;

    always_comb
    begin
        d        = q;
        sel      = pixUseFg ? cfg.fgMix : cfg.bgMix;
        unique case (sel.src)
            dep_pkg::DEP_SRC_BG:   newColor = bgColor;
            dep_pkg::DEP_SRC_FG:   newColor = fgColor;
            dep_pkg::DEP_SRC_HOST: newColor = hostColor;
            dep_pkg::DEP_SRC_MEM:  newColor = curColor;
        endcase
        if (pixTransfer)
            newColor = newColor & cfg.planeMask;
        match    = (newColor == cfg.compareValue);
        suppress = cfg.compareEn && (cfg.comparePol ? !match : match);
        d.valid  = pixReq;
        if (pixReq)
        begin
            d.color = dep_mix(sel.mix, curColor, newColor);
            d.we    = suppress ? 32'h0000_0000 : writeMask;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            q <= '{1'b0, `DEP_RST_WORD, `DEP_RST_WORD};
        else
            q <= d;
    end

    assign pixOutValid = q.valid;
    assign pixOut      = q.color;
    assign pixWe       = q.we;

endmodule

// file: rtl/dep_regs.sv
// Pixel write path register bank of the 2D drawing engine
`timescale 1ns/100ps
`include "dep_map.svh"
module dep_regs
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Host register access
    input  wire logic [15:0] hostAddr,
    input  wire logic        hostWrite,
    input  wire logic        hostRead,
    input  wire logic        hostDword,
    input  wire logic        hostMmio,
    input  wire logic [31:0] hostWrData,
    output logic [31:0]      hostRdData,
    output logic             hostRdValid,
    // Engine mode
    input  wire logic        pixel32Mode,
    // Pixel request
    input  wire logic        pixReq,
    input  wire logic        pixUseFg,
    input  wire logic        pixTransfer,
    input  wire logic [31:0] bgColor,
    input  wire logic [31:0] fgColor,
    input  wire logic [31:0] hostColor,
    input  wire logic [31:0] curColor,
    input  wire logic [31:0] writeMask,
    // Pixel result
    output logic             pixOutValid,
    output logic [31:0]      pixOut,
    output logic [31:0]      pixWe,
    // Geometry to the drawing engine
    output logic [11:0]      rectHeight,
    output logic [11:0]      clipTop,
    output logic [11:0]      clipLeft
);

    // ------------------------------------------------------------
    // Access width helpers
    // ------------------------------------------------------------

    function automatic logic [1:0] dep_lanes(input logic full,
                                             input logic px32,
                                             input logic upper);
        if (full)
            dep_lanes = 2'b11;
        else if (px32 && upper)
            dep_lanes = 2'b10;
        else
            dep_lanes = 2'b01;
    endfunction

    function automatic logic [31:0] dep_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [1:0]  lanes);
        unique case (lanes)
            2'b11:   dep_merge = data;
            2'b10:   dep_merge = {data[15:0], old[15:0]};
            default: dep_merge = {old[31:16], data[15:0]};
        endcase
    endfunction

    function automatic logic [31:0] dep_pick(input logic [31:0] val,
                                             input logic [1:0]  lanes);
        unique case (lanes)
            2'b11:   dep_pick = val;
            2'b10:   dep_pick = {`DEP_RST_HALF, val[31:16]};
            default: dep_pick = {`DEP_RST_HALF, val[15:0]};
        endcase
    endfunction

    // Reserved mix bits are dropped on write and read as zero
    function automatic logic [31:0] dep_mix_word(input dep_pkg::dep_mix_t m);
        dep_mix_word = {25'h000_0000, m.src, 1'b0, m.mix};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    dep_pkg::dep_regs_st_t q;
    dep_pkg::dep_regs_st_t d;

    logic        fullWord;
    logic        split;
    logic [1:0]  lanes;
    logic        toggle;
    logic        pushValid;
    logic        flushPipe;
    logic        commitValid;
    logic [15:0] commitWord;
    logic [15:0] readback;

    dep_cfg_if cfgBus ();

    // ------------------------------------------------------------
    // Indexed write pipeline
    // ------------------------------------------------------------

    dep_wr_pipe u_pipe
    (
        .core_clk    (core_clk),
        .rst         (rst),
        .pushValid   (pushValid),
        .pushWord    (hostWrData[15:0]),
        .flush       (flushPipe),
        .commitValid (commitValid),
        .commitWord  (commitWord)
    );

    // ------------------------------------------------------------
    // Pixel mix unit
    // ------------------------------------------------------------

    dep_mix_unit u_mix
    (
        .core_clk    (core_clk),
        .rst         (rst),
        .cfg         (cfgBus.mixu),
        .pixReq      (pixReq),
        .pixUseFg    (pixUseFg),
        .pixTransfer (pixTransfer),
        .bgColor     (bgColor),
        .fgColor     (fgColor),
        .hostColor   (hostColor),
        .curColor    (curColor),
        .writeMask   (writeMask),
        .pixOutValid (pixOutValid),
        .pixOut      (pixOut),
        .pixWe       (pixWe)
    );

    assign cfgBus.bgMix        = q.bgMix;
    assign cfgBus.fgMix        = q.fgMix;
    assign cfgBus.compareEn    = q.misc[`DEP_MISC_CMPEN];
    assign cfgBus.comparePol   = q.misc[`DEP_MISC_POL];
    assign cfgBus.compareValue = q.cmpValue;
    assign cfgBus.planeMask    = q.planeMask;

    // ------------------------------------------------------------
    // Readback selection
    // ------------------------------------------------------------

    always_comb
    begin
        unique case (q.readIdx)
            `DEP_RB_HEIGHT: readback = {`DEP_IX_HEIGHT, q.height};
            `DEP_RB_TOP:    readback = {`DEP_IX_TOP, q.clipTop};
            `DEP_RB_LEFT:   readback = {`DEP_IX_LEFT, q.clipLeft};
            `DEP_RB_MISC:   readback = {`DEP_IX_MISC, q.misc};
            // Registers kept outside this bank read as zero
            default:        readback = `DEP_RST_HALF;
        endcase
    end

    // ------------------------------------------------------------
    // Host access and register update
    // ------------------------------------------------------------

    always_comb
    begin
        d         = q;
        d.rdValid = 1'b0;
        toggle    = 1'b0;
        pushValid = 1'b0;
        flushPipe = 1'b0;
        // 16-bit access under wide not guarded
        fullWord  = hostDword && (hostMmio || q.misc[`DEP_MISC_WIDE]);
        split     = !fullWord && pixel32Mode;
        lanes     = dep_lanes(fullWord, pixel32Mode, q.misc[`DEP_MISC_UPPER]);

        if (hostRead)
        begin
            d.rdValid = 1'b1;
            d.rdData  = `DEP_RST_WORD;
            unique case (hostAddr)
                `DEP_OFS_CMP:
                begin
                    d.rdData = dep_pick(q.cmpValue, lanes);
                    toggle   = split;
                end
                `DEP_OFS_MASK:
                begin
                    d.rdData = dep_pick(q.planeMask, lanes);
                    toggle   = split;
                end
                `DEP_OFS_BGMIX:
                    d.rdData = dep_mix_word(q.bgMix);
                `DEP_OFS_FGMIX:
                    d.rdData = dep_mix_word(q.fgMix);
                `DEP_OFS_IDX:
                begin
                    d.rdData  = {`DEP_RST_HALF, readback};
                    d.readIdx = q.readIdx + 4'h1;
                end
                default:
                    d.rdData = `DEP_RST_WORD;
            endcase
        end

        if (hostWrite)
        begin
            unique case (hostAddr)
                `DEP_OFS_CMP:
                begin
                    d.cmpValue = dep_merge(q.cmpValue, hostWrData, lanes);
                    toggle     = split;
                end
                `DEP_OFS_MASK:
                begin
                    d.planeMask = dep_merge(q.planeMask, hostWrData, lanes);
                    toggle      = split;
                end
                `DEP_OFS_BGMIX:
                    d.bgMix = dep_pkg::dep_mix_t'({hostWrData[6:5], hostWrData[3:0]});
                `DEP_OFS_FGMIX:
                    d.fgMix = dep_pkg::dep_mix_t'({hostWrData[6:5], hostWrData[3:0]});
                `DEP_OFS_IDX:
                begin
                    if (hostWrData[15:12] == `DEP_IX_RDSEL)
                        d.readIdx = hostWrData[3:0];
                    else
                        pushValid = 1'b1;
                end
                // any command write drains held write
                `DEP_OFS_CMD:
                    flushPipe = 1'b1;
                default:
                    flushPipe = 1'b0;
            endcase
        end

        if (commitValid)
        begin
            unique case (commitWord[15:12])
                `DEP_IX_HEIGHT: d.height   = commitWord[11:0];
                `DEP_IX_TOP:    d.clipTop  = commitWord[11:0];
                `DEP_IX_LEFT:   d.clipLeft = commitWord[11:0];
                `DEP_IX_MISC:   d.misc     = commitWord[11:0];
                // Indices served elsewhere in the engine
                default:        d.misc     = d.misc;
            endcase
        end

        if (toggle)
            d.misc[`DEP_MISC_UPPER] = ~d.misc[`DEP_MISC_UPPER];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '{`DEP_RST_WORD, `DEP_RST_WORD, 6'h00, 6'h00,
                   `DEP_RST_FIELD, `DEP_RST_FIELD, `DEP_RST_FIELD,
                   `DEP_RST_FIELD, 4'h0, `DEP_RST_WORD, 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign hostRdData  = q.rdData;
    assign hostRdValid = q.rdValid;
    assign rectHeight  = q.height;
    assign clipTop     = q.clipTop;
    assign clipLeft    = q.clipLeft;

endmodule

// file: testbench/dep_regs_chk.sv
// Assertion checker on the pixel register bank ports
`timescale 1ns/100ps
`include "dep_map.svh"
module dep_regs_chk
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Host access
    input wire logic [15:0] hostAddr,
    input wire logic        hostWrite,
    input wire logic        hostRead,
    input wire logic [31:0] hostWrData,
    input wire logic [31:0] hostRdData,
    input wire logic        hostRdValid,
    // Pixel path
    input wire logic        pixReq,
    input wire logic [31:0] writeMask,
    input wire logic        pixOutValid,
    input wire logic [31:0] pixOut,
    input wire logic [31:0] pixWe,
    // Geometry
    input wire logic [11:0] rectHeight,
    input wire logic [11:0] clipTop,
    input wire logic [11:0] clipLeft
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rd_answer: assert property (hostRead |=> hostRdValid)
        else $error("no read answer");
    a_rd_quiet: assert property (!hostRead |=> !hostRdValid && $stable(hostRdData))
        else $error("read data moved");
    a_pix_answer: assert property (pixReq |=> pixOutValid)
        else $error("no pixel result");
    a_pix_hold: assert property (!pixReq |=> !pixOutValid && $stable({pixOut, pixWe}))
        else $error("pixel result moved");
    a_we_in_mask: assert property (pixReq |=> (pixWe & ~$past(writeMask)) == 32'h0000_0000)
        else $error("write outside mask");
    a_unmapped_zero: assert property (hostRead && !(hostAddr inside {`DEP_OFS_CMD,
        `DEP_OFS_MASK, `DEP_OFS_CMP, `DEP_OFS_BGMIX, `DEP_OFS_FGMIX, `DEP_OFS_IDX})
        |=> hostRdData == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_mix_resv: assert property (hostRead && hostAddr inside {`DEP_OFS_BGMIX,
        `DEP_OFS_FGMIX} |=> (hostRdData & 32'hFFFF_FF90) == 32'h0000_0000)
        else $error("mix reserved bits set");
    a_pipe_land: assert property (hostWrite && hostAddr == `DEP_OFS_IDX &&
        hostWrData[15:12] == `DEP_IX_LEFT ##1 hostWrite && hostAddr == `DEP_OFS_CMD
        |-> ##3 clipLeft == $past(hostWrData[11:0], 4))
        else $error("left limit not landed");
    a_geo_quiet: assert property (!hostWrite [*3] |=> $stable({rectHeight, clipTop, clipLeft}))
        else $error("geometry moved");
endmodule

bind dep_regs dep_regs_chk u_chk (.core_clk(core_clk), .rst(rst), .hostAddr(hostAddr),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
    .hostRdData(hostRdData), .hostRdValid(hostRdValid), .pixReq(pixReq),
    .writeMask(writeMask), .pixOutValid(pixOutValid), .pixOut(pixOut), .pixWe(pixWe),
    .rectHeight(rectHeight), .clipTop(clipTop), .clipLeft(clipLeft));

// file: testbench/dep_host_bfm.sv
// Host processor model issuing register accesses
`timescale 1ns/100ps
module dep_host_bfm
(
    // Clock
    input wire logic        core_clk,
    // Access request
    output logic [15:0]     hostAddr,
    output logic            hostWrite,
    output logic            hostRead,
    output logic            hostDword,
    output logic            hostMmio,
    output logic [31:0]     hostWrData,
    // Answer
    input wire logic [31:0] hostRdData
);
    initial
    begin
        {hostAddr, hostWrite, hostRead, hostDword, hostMmio, hostWrData} = 52'h0;
    end
    // Called after an edge; keep holds the strobe into the next access
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic dw, mm, keep, output logic [31:0] rd);
        hostWrite = w;
        hostRead = !w;
        hostAddr = a;
        hostWrData = d;
        hostDword = dw;
        hostMmio = mm;
        @(posedge core_clk);
        #2;
        rd = hostRdData;
        if (!keep)
        begin
            hostWrite = 1'b0;
            hostRead = 1'b0;
            // Released lines never show the last value
            hostAddr = ~a;
            hostWrData = ~d;
            @(posedge core_clk);
            #2;
        end
    endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the pixel register bank
`timescale 1ns/100ps
`include "dep_map.svh"
module tb;
    localparam logic [63:0] MIXTT = 64'h1428_EBD7_A965_CF03;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] hostAddr;
    logic hostWrite, hostRead, hostDword, hostMmio;
    logic [31:0] hostWrData, hostRdData;
    logic hostRdValid, pixel32Mode, pixReq, pixUseFg, pixTransfer;
    logic [31:0] bgColor, fgColor, hostColor, curColor, writeMask;
    logic pixOutValid;
    logic [31:0] pixOut, pixWe;
    logic [11:0] rectHeight, clipTop, clipLeft;
    // ------------------------------------------------------------
    // Reference model state
    // ------------------------------------------------------------
    logic [31:0] mSp [2] = '{default: 32'h0};
    logic [6:0]  mMix [2] = '{7'h00, 7'h00};
    logic [11:0] mGeo [3] = '{default: 12'h0};
    logic [11:0] mMisc = 12'h000;
    logic [3:0]  mSel = 4'h0;
    logic [15:0] pend [$];
    logic [31:0] rs = 32'h0001_11EE;
    int          n_errors = 0;
    int          checked = 0;
    int          cyc = 0;

    always #12.5 core_clk = ~core_clk;

    dep_host_bfm host (.core_clk(core_clk), .hostAddr(hostAddr), .hostWrite(hostWrite),
        .hostRead(hostRead), .hostDword(hostDword), .hostMmio(hostMmio),
        .hostWrData(hostWrData), .hostRdData(hostRdData));

    dep_regs DUT (.core_clk(core_clk), .rst(rst), .hostAddr(hostAddr), .hostWrite(hostWrite),
        .hostRead(hostRead), .hostDword(hostDword), .hostMmio(hostMmio),
        .hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
        .pixel32Mode(pixel32Mode), .pixReq(pixReq), .pixUseFg(pixUseFg),
        .pixTransfer(pixTransfer), .bgColor(bgColor), .fgColor(fgColor),
        .hostColor(hostColor), .curColor(curColor), .writeMask(writeMask),
        .pixOutValid(pixOutValid), .pixOut(pixOut), .pixWe(pixWe),
        .rectHeight(rectHeight), .clipTop(clipTop), .clipLeft(clipLeft));

    function automatic logic [31:0] rnd();
        rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
        return rs;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic commit();
        logic [15:0] w;
        if (pend.size() != 0)
        begin
            w = pend.pop_front();
            if (w[15:12] < 4'h3)
                mGeo[w[15:12]] = w[11:0];
            else if (w[15:12] == `DEP_IX_MISC)
                mMisc = w[11:0];
        end
    endtask

    // Host access mirrored in the model; reads compared
    task automatic ha(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic dw, mm, keep);
        logic [31:0] rd, e;
        logic        sp, full, hi;
        host.acc(w, a, d, dw, mm, keep, rd);
        sp = (a == `DEP_OFS_MASK);
        full = dw && (mm || mMisc[`DEP_MISC_WIDE]);
        hi = !full && pixel32Mode && mMisc[`DEP_MISC_UPPER];
        e = 32'h0;
        if (a == `DEP_OFS_CMD)
            commit();
        else if (a == `DEP_OFS_BGMIX || a == `DEP_OFS_FGMIX)
        begin
            if (w)
                mMix[a == `DEP_OFS_FGMIX] = d[6:0] & 7'h6F;
            e = {25'h0, mMix[a == `DEP_OFS_FGMIX]};
        end
        else if (a == `DEP_OFS_IDX && w && d[15:12] == `DEP_IX_RDSEL)
            mSel = d[3:0];
        else if (a == `DEP_OFS_IDX && w)
        begin
            commit();
            pend.push_back(d[15:0]);
        end
        else if (a == `DEP_OFS_IDX)
        begin
            if (mSel < 4'h3)
                e = {16'h0, mSel, mGeo[mSel]};
            else if (mSel == `DEP_RB_MISC)
                e = {16'h0, `DEP_IX_MISC, mMisc};
            mSel = mSel + 4'h1;
        end
        else if (sp || a == `DEP_OFS_CMP)
        begin
            if (w && full)
                mSp[sp] = d;
            else if (w && hi)
                mSp[sp][31:16] = d[15:0];
            else if (w)
                mSp[sp][15:0] = d[15:0];
            e = full ? mSp[sp] : {16'h0, hi ? mSp[sp][31:16] : mSp[sp][15:0]};
            if (!full && pixel32Mode)
                mMisc[`DEP_MISC_UPPER] = !mMisc[`DEP_MISC_UPPER];
        end
        if (!w)
            check(full && a != `DEP_OFS_IDX ? rd : {16'h0, rd[15:0]}, e);
    endtask

    task automatic px(input logic fg, tr, eq);
        logic [31:0] n, r, we;
        logic [6:0]  m;
        pixUseFg = fg;
        pixTransfer = tr;
        bgColor = rnd();
        fgColor = eq ? mSp[0] : rnd();
        hostColor = rnd();
        curColor = rnd();
        writeMask = rnd();
        pixReq = 1'b1;
        m = mMix[fg];
        n = m[6] ? (m[5] ? curColor : hostColor) : (m[5] ? fgColor : bgColor);
        if (tr)
            n = n & mSp[1];
        for (int i = 0; i < 32; i++)
            r[i] = MIXTT[{m[3:0], curColor[i], n[i]}];
        we = (mMisc[`DEP_MISC_CMPEN] && ((n == mSp[0]) != mMisc[`DEP_MISC_POL])) ? 0 : writeMask;
        @(posedge core_clk);
        #2;
        pixReq = 1'b0;
        check(pixOut, r);
        check(pixWe, we);
        curColor = ~curColor;
        writeMask = ~writeMask;
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        {pixel32Mode, pixReq, pixUseFg, pixTransfer} = 4'h0;
        {bgColor, fgColor, hostColor, curColor, writeMask} = 160'h0;
        repeat (6) @(posedge core_clk);
        #2;
        rst = 1'b0;
        ha(0, `DEP_OFS_BGMIX, 32'h0, 0, 0, 0);
        ha(1, `DEP_OFS_BGMIX, 32'hFFFF_FFFF, 0, 0, 0);
        ha(0, `DEP_OFS_BGMIX, 32'h0, 0, 0, 0);
        ha(1, 16'h1234, rnd(), 1, 1, 0);
        ha(0, 16'h1234, 32'h0, 1, 1, 0);
        ha(1, `DEP_OFS_MASK, rnd(), 1, 1, 0);
        $display("test registers done");
        for (int i = 0; i < 64; i++)
        begin
            ha(1, i[0] ? `DEP_OFS_FGMIX : `DEP_OFS_BGMIX,
               (rnd() & 32'hFFFF_FF90) | {25'h0, i[5:4], 1'b0, i[3:0]}, 0, 0, 0);
            px(i[0], rs[3], 1'b0);
        end
        $display("test mix done");
        for (int k = 0; k < 3; k++)
            ha(1, `DEP_OFS_IDX, {16'h0, k[3:0], 12'h000} | (rnd() & 32'h0000_0FFF), 0, 0, 0);
        idle(4);
        check({20'h0, clipLeft}, {20'h0, mGeo[2]});
        check({8'h0, rectHeight, clipTop}, {8'h0, mGeo[0], mGeo[1]});
        // NOP drawing command flushes
        ha(1, `DEP_OFS_CMD, rnd() & 32'h0000_1FFF, 0, 0, 0);
        idle(3);
        check({20'h0, clipLeft}, {20'h0, mGeo[2]});
        ha(1, `DEP_OFS_IDX, 32'h0000_2000 | (rnd() & 32'h0000_0FFF), 0, 0, 1);
        ha(1, `DEP_OFS_CMD, 32'h0000_0000, 0, 0, 0);
        idle(3);
        check({20'h0, clipLeft}, {20'h0, mGeo[2]});
        ha(1, `DEP_OFS_IDX, 32'h0000_F000, 0, 0, 0);
        repeat (4) ha(0, `DEP_OFS_IDX, 32'h0, 0, 0, 0);
        $display("test indexed done");
        for (int p = 0; p < 4; p++)
        begin
            ha(1, `DEP_OFS_IDX, {16'h0000, 8'hE1, p[0], 7'h00}, 0, 0, 0);
            ha(1, `DEP_OFS_CMD, 32'h0000_0000, 0, 0, 0);
            idle(3);
            ha(1, `DEP_OFS_CMP, rnd(), 1, 1, 0);
            ha(1, `DEP_OFS_FGMIX, 32'h0000_0027, 0, 0, 0);
            px(1'b1, 1'b0, p[1]);
        end
        $display("test compare done");
        ha(1, `DEP_OFS_IDX, 32'h0000_E000, 0, 0, 0);
        ha(1, `DEP_OFS_CMD, 32'h0000_0000, 0, 0, 0);
        idle(3);
        pixel32Mode = 1'b1;
        for (int j = 0; j < 2; j++)
        begin
            ha(1, j ? `DEP_OFS_MASK : `DEP_OFS_CMP, rnd(), 0, 0, 0);
            ha(1, j ? `DEP_OFS_MASK : `DEP_OFS_CMP, rnd(), 0, 0, 0);
            ha(0, j ? `DEP_OFS_MASK : `DEP_OFS_CMP, 32'h0, 1, 1, 0);
            ha(0, j ? `DEP_OFS_MASK : `DEP_OFS_CMP, 32'h0, 1, 0, 0);
        end
        ha(1, `DEP_OFS_IDX, 32'h0000_F006, 0, 0, 0);
        ha(0, `DEP_OFS_IDX, 32'h0, 0, 0, 0);
        ha(1, `DEP_OFS_IDX, 32'h0000_E200, 0, 0, 0);
        ha(1, `DEP_OFS_CMD, 32'h0000_0000, 0, 0, 0);
        idle(3);
        // Wide mode: doubleword accesses only
        ha(1, `DEP_OFS_CMP, rnd(), 1, 0, 0);
        ha(0, `DEP_OFS_CMP, 32'h0, 1, 0, 0);
        $display("test halves done");
        report_and_stop();
    end
endmodule
